// file: src/kil_pkg.sv
// Package of constants for the keypad interrupt latch
package kil_pkg;
  // Pin count and bus widths
  localparam int KIL_PINS = 8;
  localparam int KIL_AW = 12;
  // Register byte offsets
  localparam logic [11:0] KIL_OFS_STATUS = 12'h000;
  localparam logic [11:0] KIL_OFS_ENABLE = 12'h004;
  localparam logic [11:0] KIL_OFS_DATA = 12'h008;
  localparam logic [11:0] KIL_OFS_DIR = 12'h00C;
  // Status/control field positions
  localparam int KIL_BIT_MODE = 0;
  localparam int KIL_BIT_MASK = 1;
  localparam int KIL_BIT_ACK = 2;
  localparam int KIL_BIT_PEND = 3;
  // Reset values
  localparam logic [7:0] KIL_RST_ENABLE = 8'h00;
  localparam logic [7:0] KIL_RST_DATA = 8'h00;
  localparam logic [7:0] KIL_RST_DIR = 8'h00;
  localparam logic KIL_RST_MODE = 1'b0;
  localparam logic KIL_RST_MASK = 1'b0;
  // Synchroniser depth in flip-flops
  localparam int KIL_SYNC_STAGES = 2;
  // Vector location of this request, high byte first
  localparam logic [15:0] KIL_VEC_HI = 16'hFFE0;
  localparam logic [15:0] KIL_VEC_LO = 16'hFFE1;
  // AHB transfer type and response codes
  localparam logic [1:0] KIL_HTRANS_IDLE = 2'h0;
  localparam logic [1:0] KIL_HTRANS_NONSEQ = 2'h2;
  localparam logic KIL_HRESP_OKAY = 1'b0;
  // Trigger sense modes
  typedef enum logic {KIL_EDGE_ONLY, KIL_EDGE_LEVEL} kil_sense_t;
endpackage

// file: src/kil_evt_if.sv
// Interface joining pin sampler, request latch and register block
`timescale 1ns/1ns
interface kil_evt_if;
  import kil_pkg::*;
  logic [KIL_PINS-1:0] pins_sync; // Pin levels on the bus clock
  logic [KIL_PINS-1:0] pin_en; // Pin source enables
  kil_sense_t sense; // Trigger sense select
  logic ack; // One-cycle acknowledge pulse
  logic pending; // Latched request
  modport sampler (output pins_sync);
  modport latch (input pins_sync, input pin_en, input sense, input ack, output pending);
  modport ctrl (input pins_sync, input pending, output pin_en, output sense, output ack);
endinterface

// file: src/kil_pin_sync.sv
// Two-stage synchroniser for the port A input lines
`timescale 1ns/1ns
module kil_pin_sync
  import kil_pkg::*;
#(
  parameter int WIDTH = KIL_PINS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] pins_async,
  kil_evt_if.sampler evt
);
  // First stage, read only by the second; resets high as idle pins do
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // Plain two-flop chain per line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= pins_async;
      sync_q <= meta_q;
    end
  end

  assign evt.pins_sync = sync_q;
endmodule

// file: src/kil_req_latch.sv
// Request latch with edge and edge-plus-level sensing
`timescale 1ns/1ns
module kil_req_latch
  import kil_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  kil_evt_if.latch evt
);
  logic any_low; // Some enabled pin is low
  logic any_low_q; // Same, one cycle earlier
  logic fall; // All high before, some low now
  logic latch_q;
  logic acked_q; // Acknowledge seen, level mode waiting

  // Only enabled pins take part
  assign any_low = |(evt.pin_en & ~evt.pins_sync);
  // Combined high-to-low edge; a second pin going low is not an edge
  assign fall = any_low & ~any_low_q;

  // Previous combined state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      any_low_q <= 1'b0;
    end else begin
      any_low_q <= any_low;
    end
  end

  // The latch; a new edge wins over an acknowledge in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_q <= 1'b0;
      acked_q <= 1'b0;
    end else if (fall) begin
      latch_q <= 1'b1;
      acked_q <= 1'b0;
    end else if (evt.sense == KIL_EDGE_ONLY) begin
      acked_q <= 1'b0;
      if (evt.ack) begin
        latch_q <= 1'b0;
      end
    end else if (latch_q && (evt.ack || acked_q) && !any_low) begin
      latch_q <= 1'b0;
      acked_q <= 1'b0;
    end else if (latch_q && evt.ack) begin
      acked_q <= 1'b1;
    end
  end

  assign evt.pending = latch_q;
endmodule

// file: src/kil_keypad_irq_unit.sv
// Keypad interrupt latch top with AHB-Lite registers and port A pins
`timescale 1ns/1ns
module kil_keypad_irq_unit
  import kil_pkg::*;
#(
  parameter int PINS = KIL_PINS
) (
  // Bus clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // CPU interrupt side
  input wire logic vector_fetch,
  input wire logic [15:0] vector_addr,
  input wire logic break_state,
  input wire logic break_clear_enable,
  output logic irq_request,
  // Port A lines, split into in, out and enable, plus pull-up enables
  input wire logic [PINS-1:0] port_a_lines_i,
  output logic [PINS-1:0] port_a_lines_o,
  output logic [PINS-1:0] port_a_lines_oe_n,
  output logic [PINS-1:0] pullup_en
);
  kil_evt_if evt (); // Link to sampler and latch

  // Register state
  logic [PINS-1:0] pin_source_enables_q; // Source enables
  logic [PINS-1:0] port_a_direction_q; // One drives the pin unless its source is enabled
  logic [PINS-1:0] port_a_data_q; // Output data latch
  logic request_mask_q; // Blocks the CPU request
  kil_sense_t trigger_sense_select_q; // Edge or edge-level
  logic request_acknowledge_q; // Software acknowledge pulse

  // Bus pipeline registers
  logic wr_pend_q; // Write awaits its data phase
  logic [KIL_AW-1:0] wr_addr_q; // Address of that write
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic irq_q;
  logic [PINS-1:0] pin_o_q;
  logic [PINS-1:0] pin_oe_n_q;
  logic [PINS-1:0] pullup_q;

  // Decode of the address phase
  logic addr_ok; // Valid transfer accepted this cycle
  logic rd_go; // Read taken
  logic wr_go; // Write taken
  logic [KIL_AW-1:0] a_off; // Low address bits
  logic sw_ack; // Software acknowledge allowed now
  logic vec_ack; // Vector fetch of this request
  logic [PINS-1:0] pin_view; // What a data read returns
  logic [31:0] rd_word; // Read word before registering

  // Pin sampler and request latch
  kil_pin_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pins_async(port_a_lines_i),
    .evt(evt)
  );

  kil_req_latch u_latch (
    .hclk(hclk),
    .hresetn(hresetn),
    .evt(evt)
  );

  // Control values handed to the latch
  assign evt.pin_en = pin_source_enables_q;
  assign evt.sense = trigger_sense_select_q;
  // Either acknowledge source clears the same way
  assign evt.ack = request_acknowledge_q || vec_ack;

  // Vector fetch of the high vector byte marks the acknowledge
  assign vec_ack = vector_fetch && (vector_addr == KIL_VEC_HI);

  // Address phase decode; only NONSEQ moves anything
  assign addr_ok = hsel && hready && (htrans == KIL_HTRANS_NONSEQ);
  assign rd_go = addr_ok && !hwrite;
  assign wr_go = addr_ok && hwrite;
  assign a_off = haddr[KIL_AW-1:0];

  // During break a software acknowledge is blocked unless clear-enable is set; a vector fetch still clears the latch
  assign sw_ack = !break_state || break_clear_enable;

  // Read pin level only where the direction bit is zero
  assign pin_view = (evt.pins_sync & ~port_a_direction_q) |
                    (port_a_data_q & port_a_direction_q);

  // Read word mux, unmapped offsets read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (a_off)
      KIL_OFS_STATUS: begin
        // Acknowledge bit and upper nibble read zero
        rd_word[KIL_BIT_PEND] = evt.pending;
        rd_word[KIL_BIT_MASK] = request_mask_q;
        rd_word[KIL_BIT_MODE] = trigger_sense_select_q;
      end
      KIL_OFS_ENABLE: begin
        rd_word[PINS-1:0] = pin_source_enables_q;
      end
      KIL_OFS_DATA: begin
        rd_word[PINS-1:0] = pin_view;
      end
      KIL_OFS_DIR: begin
        rd_word[PINS-1:0] = port_a_direction_q;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Read data registered so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_go) begin
      hrdata_q <= rd_word;
    end else if (addr_ok) begin
      hrdata_q <= 32'h0000_0000;
    end
  end

  // Zero-wait slave: ready never drops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
    end else begin
      hreadyout_q <= 1'b1;
    end
  end

  // Write address held for its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else if (hready) begin
      wr_pend_q <= wr_go;
      if (wr_go) begin
        wr_addr_q <= a_off;
      end
    end
  end

  // Status/control: mask and sense select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      request_mask_q <= KIL_RST_MASK;
      trigger_sense_select_q <= KIL_EDGE_ONLY;
    end else if (wr_pend_q && wr_addr_q == KIL_OFS_STATUS) begin
      request_mask_q <= hwdata[KIL_BIT_MASK];
      // One selects edge plus level
      trigger_sense_select_q <= kil_sense_t'(hwdata[KIL_BIT_MODE]);
    end
  end

  // Acknowledge bit is a one-cycle pulse, never stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      request_acknowledge_q <= 1'b0;
    end else begin
      request_acknowledge_q <= wr_pend_q && (wr_addr_q == KIL_OFS_STATUS) &&
                               hwdata[KIL_BIT_ACK] && sw_ack;
    end
  end

  // Pin source enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_source_enables_q <= KIL_RST_ENABLE;
    end else if (wr_pend_q && wr_addr_q == KIL_OFS_ENABLE) begin
      pin_source_enables_q <= hwdata[PINS-1:0];
    end
  end

  // Port data latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_a_data_q <= KIL_RST_DATA;
    end else if (wr_pend_q && wr_addr_q == KIL_OFS_DATA) begin
      port_a_data_q <= hwdata[PINS-1:0];
    end
  end

  // Port direction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_a_direction_q <= KIL_RST_DIR;
    end else if (wr_pend_q && wr_addr_q == KIL_OFS_DIR) begin
      port_a_direction_q <= hwdata[PINS-1:0];
    end
  end

  // Pin drivers; an enabled source never drives, whatever direction says
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_o_q <= '0;
      pin_oe_n_q <= '1;
      pullup_q <= '0;
    end else begin
      pin_o_q <= port_a_data_q;
      pin_oe_n_q <= ~(port_a_direction_q & ~pin_source_enables_q);
      pullup_q <= pin_source_enables_q;
    end
  end

  // CPU request, gated by the mask; one cycle behind the latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= evt.pending && !request_mask_q;
    end
  end

  // Outputs straight from flip-flops, except hresp tied to OKAY
  assign hreadyout = hreadyout_q;
  assign hresp = KIL_HRESP_OKAY;
  assign hrdata = hrdata_q;
  assign irq_request = irq_q;
  assign port_a_lines_o = pin_o_q;
  assign port_a_lines_oe_n = pin_oe_n_q;
  assign pullup_en = pullup_q;
endmodule

// file: tb/kil_keypad_irq_unit_sva.sv
// Checker bound to the keypad interrupt latch top
`timescale 1ns/1ns
module kil_keypad_irq_unit_sva
  import kil_pkg::*;
#(
  parameter int PINS = KIL_PINS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic break_state,
  input wire logic break_clear_enable,
  input wire logic irq_request,
  input wire logic [PINS-1:0] port_a_lines_i,
  input wire logic [PINS-1:0] port_a_lines_oe_n,
  input wire logic [PINS-1:0] pullup_en
);
  logic wr_q, rd_q, mode_q, mask_q; // Data phase kinds, shadow bits
  logic [11:0] ad_q; // Data phase offset
  logic [PINS-1:0] en_q; // Shadow of pin enables
  logic [3:0] hi_q; // Quiet cycles on enabled pins
  wire st_w = wr_q && ad_q == KIL_OFS_STATUS && hwdata[2] && hwdata[1:0] == 2'h0; // Bare ack write
  wire brk = break_state && !break_clear_enable; // Ack blocked
  // Track data phases; address kept every cycle, gated by kind
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      ad_q <= 12'h000;
    end else begin
      wr_q <= hsel && hready && htrans == KIL_HTRANS_NONSEQ && hwrite;
      rd_q <= hsel && hready && htrans == KIL_HTRANS_NONSEQ && !hwrite;
      ad_q <= haddr[11:0];
    end
  end
  // Shadow of sense, mask and enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= 1'b0;
      mask_q <= 1'b0;
      en_q <= '0;
    end else if (wr_q && ad_q == KIL_OFS_STATUS) begin
      mode_q <= hwdata[KIL_BIT_MODE];
      mask_q <= hwdata[KIL_BIT_MASK];
    end else if (wr_q && ad_q == KIL_OFS_ENABLE) begin
      en_q <= hwdata[PINS-1:0];
    end
  end
  // Saturating count, so no stray edge can race an ack
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_q <= 4'h0;
    end else if ((port_a_lines_i | ~en_q) != '1) begin
      hi_q <= 4'h0;
    end else if (hi_q != 4'hF) begin
      hi_q <= hi_q + 4'h1;
    end
  end
  a_reset_quiet: assert property (@(posedge hclk)
    !hresetn |-> !irq_request && pullup_en == '0) else $error("request or pull-up in reset");
  a_mask_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
    mask_q && $past(mask_q) |-> !irq_request) else $error("masked request reached cpu");
  a_pull_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    $stable(en_q) |-> pullup_en == en_q) else $error("pull-up differs from enable");
  a_input_forced: assert property (@(posedge hclk) disable iff (!hresetn)
    $stable(en_q) |-> (en_q & ~port_a_lines_oe_n) == '0) else $error("enabled pin driven");
  a_ack_reads0: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_q && ad_q == KIL_OFS_STATUS |-> hrdata[2] == 1'b0 && hrdata[31:4] == '0) else $error("status reads ones");
  a_level_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_q && !mask_q && (~port_a_lines_i & en_q) != '0) [*6] |-> irq_request) else $error("level request lost");
  a_edge_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    st_w && !brk && !mode_q && hi_q > 4'h4 |-> ##[1:4] !irq_request) else $error("ack did not clear");
  a_break_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    st_w && brk && !mode_q && irq_request |-> ##3 irq_request) else $error("ack in break cleared");
endmodule
bind kil_keypad_irq_unit kil_keypad_irq_unit_sva #(.PINS(PINS)) kil_keypad_irq_unit_sva_inst (.*);

// file: tb/kil_keys.sv
// Model of keys and wiring on the port A lines
`timescale 1ns/1ns
module kil_keys (
  input wire logic hclk,
  input wire logic [7:0] press,
  input wire logic [7:0] pu,
  input wire logic [7:0] dout,
  input wire logic [7:0] oe_n,
  output logic [7:0] line
);
  logic [7:0] flt_q = 8'h00; // Floating pattern
  // Undriven lines keep flipping so they never look settled
  always_ff @(posedge hclk) begin
    flt_q <= ~flt_q;
  end
  // Closed key wins, then driver, then pull-up, then float
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      line[i] = press[i] ? 1'b0 : !oe_n[i] ? dout[i] : pu[i] ? 1'b1 : flt_q[i];
    end
  end
endmodule

// file: tb/kil_keypad_irq_unit_tb_top.sv
// Testbench top for the keypad interrupt latch
`timescale 1ns/1ns
module kil_keypad_irq_unit_tb_top;
  import kil_pkg::*;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e;} kil_row_t;
  logic hclk = 1'b0, hresetn = 1'b1, hsel = 1'b0, hwrite = 1'b0, vf = 1'b0, brk = 1'b0, bce = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = KIL_HTRANS_IDLE;
  logic [15:0] va = 16'h0000;
  logic [7:0] press = 8'h00, lines_i, lines_o, oe_n, pu;
  logic hreadyout, hresp, irq;
  int miscompares = 0, tests_run = 0;
  // Write, read back expectation
  kil_row_t rows [7] = '{'{KIL_OFS_STATUS, 32'hFFFFFFF7, 32'h3}, '{KIL_OFS_STATUS, 32'h0, 32'h0},
    '{KIL_OFS_ENABLE, 32'hA5, 32'hA5}, '{KIL_OFS_ENABLE, 32'hFFFFFF00, 32'h0},
    '{KIL_OFS_DIR, 32'hFF, 32'hFF}, '{KIL_OFS_DATA, 32'h3C, 32'h3C}, '{12'h010, 32'h55, 32'h0}};
  always #5 hclk = ~hclk;
  kil_keypad_irq_unit kil_keypad_irq_unit_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .vector_fetch(vf),
    .vector_addr(va),
    .break_state(brk),
    .break_clear_enable(bce),
    .irq_request(irq),
    .port_a_lines_i(lines_i),
    .port_a_lines_o(lines_o),
    .port_a_lines_oe_n(oe_n),
    .pullup_en(pu)
  );
  kil_keys kil_keys_inst (.hclk(hclk), .press(press), .pu(pu), .dout(lines_o), .oe_n(oe_n), .line(lines_i));
  // One single transfer; entered just after an edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= KIL_HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= KIL_HTRANS_IDLE;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic keys(input logic [7:0] k, input int n);
    press <= k;
    idle(n);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    // Reset asserted at time zero, released on an edge
    hresetn <= 1'b0;
    idle(12);
    hresetn <= 1'b1;
    idle(1);
    rchk(KIL_OFS_STATUS, 32'h0);
    rchk(KIL_OFS_ENABLE, 32'h0);
    chk(32'(oe_n), 32'hFF);
    chk(32'(hresp), 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    // Output latch reaches the pins
    chk(32'(lines_o), 32'h3C);
    // Edge mode, pins 0 and 1 enabled, device driving the rest
    wr(KIL_OFS_ENABLE, 32'h03);
    wr(KIL_OFS_STATUS, 32'h04);
    chk(32'(pu), 32'h03);
    chk(32'(oe_n), 32'h03);
    keys(8'h01, 6);
    rchk(KIL_OFS_STATUS, 32'h08);
    chk(32'(irq), 32'h1);
    wr(KIL_OFS_STATUS, 32'h02);
    rchk(KIL_OFS_STATUS, 32'h0A);
    chk(32'(irq), 32'h0);
    wr(KIL_OFS_STATUS, 32'h06);
    keys(8'h03, 6);
    rchk(KIL_OFS_STATUS, 32'h02);
    keys(8'h04, 6);
    rchk(KIL_OFS_STATUS, 32'h02);
    wr(KIL_OFS_STATUS, 32'h00);
    keys(8'h02, 6);
    chk(32'(irq), 32'h1);
    va <= KIL_VEC_HI;
    vf <= 1'b1;
    idle(1);
    vf <= 1'b0;
    idle(4);
    rchk(KIL_OFS_STATUS, 32'h0);
    keys(8'h00, 4);
    wr(KIL_OFS_STATUS, 32'h04);
    keys(8'h01, 6);
    rchk(KIL_OFS_STATUS, 32'h08);
    // Acks in break, blocked then allowed
    brk <= 1'b1;
    press <= 8'h00;
    wr(KIL_OFS_STATUS, 32'h04);
    idle(4);
    rchk(KIL_OFS_STATUS, 32'h08);
    bce <= 1'b1;
    wr(KIL_OFS_STATUS, 32'h04);
    idle(4);
    rchk(KIL_OFS_STATUS, 32'h0);
    brk <= 1'b0;
    bce <= 1'b0;
    // Level mode, both orders of ack and release
    wr(KIL_OFS_STATUS, 32'h01);
    keys(8'h01, 8);
    wr(KIL_OFS_STATUS, 32'h05);
    idle(4);
    rchk(KIL_OFS_STATUS, 32'h09);
    keys(8'h00, 6);
    rchk(KIL_OFS_STATUS, 32'h01);
    keys(8'h02, 6);
    keys(8'h00, 6);
    rchk(KIL_OFS_STATUS, 32'h09);
    wr(KIL_OFS_STATUS, 32'h05);
    idle(4);
    rchk(KIL_OFS_STATUS, 32'h01);
    // Pin levels read with direction cleared
    wr(KIL_OFS_DIR, 32'h00);
    wr(KIL_OFS_ENABLE, 32'hFF);
    keys(8'h05, 6);
    rchk(KIL_OFS_DATA, 32'hFA);
    // Reset in mid-run with keys held low
    hresetn <= 1'b0;
    idle(2);
    chk(32'(irq), 32'h0);
    hresetn <= 1'b1;
    idle(1);
    rchk(KIL_OFS_STATUS, 32'h0);
    report_and_stop();
  end
endmodule
